// [hdl/ccs_top.sv]
// clock source select with fail-safe monitor, Avalon-MM register slave
// assumes cfg_* straps hold steady through reset release; pins sampled on clk
`timescale 1ns/100ps
module ccs_top import ccs_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] cfg_fosc,
    input wire logic cfg_two_speed,
    input wire logic cfg_failsafe,
    input wire logic osc_pin_in,
    input wire logic hf_osc_in,
    input wire logic lf_osc_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic sys_clk,
    output logic osc_out_o,
    output logic osc_out_oe,
    output logic osc_in_gpio_en,
    output logic osc_out_gpio_en,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // configuration strap, caught once after reset
    logic taken_reg, taken_next;
    logic [2:0] mode_reg, mode_next;
    logic two_reg, two_next;
    logic fs_reg, fs_next;
    logic ext_m;
    always_comb
    begin
        taken_next = 1'b1;
        mode_next = mode_reg;
        two_next = two_reg;
        fs_next = fs_reg;
        if (!taken_reg)
        begin
            mode_next = cfg_fosc; // RL1
            two_next = cfg_two_speed;
            fs_next = cfg_failsafe;
        end
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            taken_reg <= 1'b0;
            mode_reg <= MODE_INT_IO;
            two_reg <= 1'b0;
            fs_reg <= 1'b0;
        end
        else
        begin
            taken_reg <= taken_next;
            mode_reg <= mode_next;
            two_reg <= two_next;
            fs_reg <= fs_next;
        end
    end
    assign ext_m = taken_reg && is_ext(mode_reg);
    ////////////////////////////////////////////////////////////////////////////
    // external start-up count, fail monitor and source choice
    logic ext_prev_reg, ext_prev_next;
    logic [OST_W-1:0] ost_cnt_reg, ost_cnt_next;
    logic ost_reg, ost_next;
    logic ext_rise, fail_w, fail_pulse_w, want_int, sw_w;
    ccs_src_t sel_req, cur_w;
    ccs_ctrl_t ctrl_reg, ctrl_next;
    assign ext_rise = osc_pin_in & ~ext_prev_reg;
    always_comb
    begin
        ext_prev_next = osc_pin_in;
        ost_cnt_next = ost_cnt_reg;
        ost_next = ost_reg;
        if (ext_m && !ost_reg && ext_rise)
        begin
            ost_cnt_next = ost_cnt_reg + 1'b1;
            if (ost_cnt_reg == OST_W'(OST_EDGES - 1))
                ost_next = 1'b1;
        end
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ext_prev_reg <= 1'b0;
            ost_cnt_reg <= '0;
            ost_reg <= 1'b0;
        end
        else
        begin
            ext_prev_reg <= ext_prev_next;
            ost_cnt_reg <= ost_cnt_next;
            ost_reg <= ost_next;
        end
    end
    // watching only after start-up keeps a slow crystal from looking dead
    ccs_fail_mon u_mon (
        .clk(clk),
        .srst(srst),
        .enable(ext_m && fs_reg && ost_reg), // RL2
        .ext_rise(ext_rise),
        .fail(fail_w),
        .fail_pulse(fail_pulse_w)
    );
    // without two-speed the external source is taken at once, start-up or not
    assign want_int = !ext_m || ctrl_reg.scs_int || fail_w || (two_reg && !ost_reg); // RL2 RL8 RL10
    assign sel_req = !want_int ? SRC_EXT : (ctrl_reg.hf_sel ? SRC_HF : SRC_LF); // RL9
    ccs_clk_mux u_mux (
        .clk(clk),
        .srst(srst),
        .src({lf_osc_in, hf_osc_in, osc_pin_in}),
        .sel_req(sel_req),
        .sys_clk(sys_clk),
        .cur_sel(cur_w),
        .switching(sw_w)
    );
    ////////////////////////////////////////////////////////////////////////////
    // divide by four and pin ownership
    logic sclk_prev_reg, sclk_prev_next;
    logic [1:0] div_reg, div_next;
    logic oo_reg, oo_next, oe_reg, oe_next, ig_reg, ig_next, og_reg, og_next;
    always_comb
    begin
        sclk_prev_next = sys_clk;
        div_next = div_reg + {1'b0, sys_clk & ~sclk_prev_reg};
        oo_next = div_reg[1]; // RL4 RL6
        oe_next = taken_reg && (mode_reg == MODE_RC_OUT || mode_reg == MODE_INT_OUT); // RL4 RL6
        og_next = taken_reg && (mode_reg == MODE_EXT_CLK || mode_reg == MODE_RC_IO
            || mode_reg == MODE_INT_IO); // RL3 RL5 RL7
        ig_next = taken_reg && !is_ext(mode_reg); // RL6 RL7
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sclk_prev_reg <= 1'b0;
            div_reg <= 2'h0;
            oo_reg <= 1'b0;
            oe_reg <= 1'b0;
            ig_reg <= 1'b0;
            og_reg <= 1'b0;
        end
        else
        begin
            sclk_prev_reg <= sclk_prev_next;
            div_reg <= div_next;
            oo_reg <= oo_next;
            oe_reg <= oe_next;
            ig_reg <= ig_next;
            og_reg <= og_next;
        end
    end
    assign osc_out_o = oo_reg;
    assign osc_out_oe = oe_reg;
    assign osc_in_gpio_en = ig_reg;
    assign osc_out_gpio_en = og_reg;
    ////////////////////////////////////////////////////////////////////////////
    // register slave: one wait cycle, then the answer
    logic wait_reg, wait_next;
    logic [31:0] rd_reg, rd_next;
    ccs_evt_t stat_reg, stat_next, mask_reg, mask_next, evt;
    logic ost_q_reg, irq_reg, irq_next, wr_ok;
    function automatic logic [31:0] rd_word(input logic [3:0] a, input logic [31:0] st,
        input ccs_ctrl_t c, input ccs_evt_t s, input ccs_evt_t m);
        unique case (a)
            OFS_CTRL: rd_word = {30'h0, c};
            OFS_STATUS: rd_word = st;
            OFS_IRQ_STAT: rd_word = {30'h0, s};
            OFS_IRQ_MASK: rd_word = {30'h0, m};
            default: rd_word = 32'h0;
        endcase
    endfunction : rd_word
    logic [31:0] st_word;
    always_comb
    begin
        st_word = 32'h0;
        st_word[ST_ON_EXT] = (cur_w == SRC_EXT) && !sw_w;
        st_word[ST_OST_DONE] = ost_reg;
        st_word[ST_FAIL] = fail_w;
        st_word[ST_SWITCH] = sw_w;
        st_word[ST_MODE +: 3] = mode_reg;
    end
    assign wr_ok = avs_write && !wait_reg && avs_byteenable[0];
    assign evt = '{ost: ost_reg & ~ost_q_reg, fail: fail_pulse_w};
    always_comb
    begin
        wait_next = 1'b1;
        rd_next = rd_reg;
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        if ((avs_read || avs_write) && wait_reg)
        begin
            wait_next = 1'b0;
            rd_next = avs_read ? rd_word(avs_address, st_word, ctrl_reg, stat_reg, mask_reg) : 32'h0;
        end
        if (wr_ok && avs_address == OFS_CTRL)
            ctrl_next = avs_writedata[1:0]; // RL8 RL9
        if (wr_ok && avs_address == OFS_IRQ_MASK)
            mask_next = avs_writedata[1:0];
        // a clear in the same cycle as a new event loses
        stat_next = stat_reg;
        if (wr_ok && avs_address == OFS_IRQ_STAT)
            stat_next = stat_reg & ~avs_writedata[1:0];
        stat_next = stat_next | evt; // RL11
        irq_next = |(stat_next & mask_next); // RL11
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wait_reg <= 1'b1;
            rd_reg <= 32'h0;
            ctrl_reg <= CTRL_RST;
            mask_reg <= MASK_RST;
            stat_reg <= '0;
            ost_q_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            wait_reg <= wait_next;
            rd_reg <= rd_next;
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            ost_q_reg <= ost_reg;
            irq_reg <= irq_next;
        end
    end
    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rd_reg;
    assign irq = irq_reg;
    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_mode_held;
        @(posedge clk) disable iff (srst)
        taken_reg |=> ($stable(mode_reg) && taken_reg);
    endproperty
    a_mode_held: assert property (p_mode_held) else $error("mode changed after capture"); // RL1
    property p_extclk_pins;
        @(posedge clk) disable iff (srst)
        (taken_reg && mode_reg == MODE_EXT_CLK) |=> (osc_out_gpio_en && !osc_in_gpio_en && !osc_out_oe);
    endproperty
    a_extclk_pins: assert property (p_extclk_pins) else $error("external clock pin use wrong"); // RL3
    property p_rc_out;
        @(posedge clk) disable iff (srst)
        (taken_reg && mode_reg == MODE_RC_OUT) ##1 1'b1 |=> (osc_out_oe && !osc_out_gpio_en
            && osc_out_o == $past(div_reg[1], 1));
    endproperty
    a_rc_out: assert property (p_rc_out) else $error("rc clock out wrong"); // RL4
    property p_rc_io;
        @(posedge clk) disable iff (srst)
        (taken_reg && mode_reg == MODE_RC_IO) |=> (osc_out_gpio_en && !osc_out_oe && !osc_in_gpio_en);
    endproperty
    a_rc_io: assert property (p_rc_io) else $error("rc io pin wrong"); // RL5
    property p_int_out;
        @(posedge clk) disable iff (srst)
        (taken_reg && mode_reg == MODE_INT_OUT) |=> (osc_out_oe && osc_in_gpio_en && !osc_out_gpio_en);
    endproperty
    a_int_out: assert property (p_int_out) else $error("int clock out pins wrong"); // RL6
    property p_int_io;
        @(posedge clk) disable iff (srst)
        (taken_reg && mode_reg == MODE_INT_IO) |=> (osc_in_gpio_en && osc_out_gpio_en && !osc_out_oe);
    endproperty
    a_int_io: assert property (p_int_io) else $error("int io pins wrong"); // RL7
    property p_sw_int;
        @(posedge clk) disable iff (srst)
        (wr_ok && avs_address == OFS_CTRL && avs_writedata[CTRL_SCS]) |=> (sel_req != SRC_EXT);
    endproperty
    a_sw_int: assert property (p_sw_int) else $error("software switch ignored"); // RL8
    property p_int_speed;
        @(posedge clk) disable iff (srst)
        want_int |-> (sel_req == (ctrl_reg.hf_sel ? SRC_HF : SRC_LF));
    endproperty
    a_int_speed: assert property (p_int_speed) else $error("internal speed wrong"); // RL9
    property p_two_speed;
        @(posedge clk) disable iff (srst)
        (ext_m && two_reg && !ost_reg) |-> (sel_req != SRC_EXT);
    endproperty
    a_two_speed: assert property (p_two_speed) else $error("external used before start-up"); // RL10
    property p_fail_flag;
        @(posedge clk) disable iff (srst)
        fail_pulse_w |=> (stat_reg.fail && sel_req != SRC_EXT);
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("fail flag or switch missing"); // RL2 RL11
endmodule : ccs_top

// [hdl/ccs_pkg.sv]
// constants, codes and carriers of the clock source select block
// assumes one 25 MHz bus clock; oscillator inputs arrive sampled on it
// Function
// RL1 - eight clock modes from a three-bit config field caught at start-up
// RL2 - external modes: monitor detects lost external clock, switches to internal
// RL3 - external clock mode: clock from input pin, output pin freed for I/O
// RL4 - external RC with clock out: output pin drives system clock divided by four
// RL5 - external RC without clock out: output pin freed for I/O
// RL6 - internal with clock out: output pin drives clock/4, input pin freed
// RL7 - internal without clock out: both oscillator pins freed for I/O
// RL8 - software switches system clock between external and internal at run time
// RL9 - internal clock from high or low internal oscillator, chosen by software
// RL10 - two-speed start-up runs internal until the external oscillator settles
// RL11 - fail switch-over sets sticky readable, clearable flag that may interrupt
// RL12 - source switch is glitch-free, old source parked low before new one
package ccs_pkg;
    localparam logic [2:0] MODE_EXT_CLK = 3'h0;
    localparam logic [2:0] MODE_LOW_XTAL = 3'h1;
    localparam logic [2:0] MODE_MED_XTAL = 3'h2;
    localparam logic [2:0] MODE_HIGH_XTAL = 3'h3;
    localparam logic [2:0] MODE_RC_OUT = 3'h4;
    localparam logic [2:0] MODE_RC_IO = 3'h5;
    localparam logic [2:0] MODE_INT_OUT = 3'h6;
    localparam logic [2:0] MODE_INT_IO = 3'h7;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
    localparam int CTRL_SCS = 0;
    localparam int CTRL_HF = 1;
    localparam int ST_ON_EXT = 0;
    localparam int ST_OST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_SWITCH = 3;
    localparam int ST_MODE = 4;
    localparam int EVT_FAIL = 0;
    localparam int EVT_OST = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam int CLK_NS = 40;
    localparam int FAIL_TIME_NS = 2000;
    localparam int FAIL_CYC = (FAIL_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int FAIL_W = 6;
    localparam int OST_EDGES = 1024;
    localparam int OST_W = 10;
    typedef enum logic [1:0] {SRC_EXT, SRC_HF, SRC_LF} ccs_src_t;
    typedef struct packed {
        logic hf_sel;
        logic scs_int;
    } ccs_ctrl_t;
    typedef struct packed {
        logic ost;
        logic fail;
    } ccs_evt_t;
    function automatic logic is_ext(input logic [2:0] m);
        is_ext = (m != MODE_INT_OUT) && (m != MODE_INT_IO);
    endfunction : is_ext
endpackage : ccs_pkg

// [hdl/ccs_fail_mon.sv]
// watchdog on the external oscillator edges
// assumes ext_rise is a one-cycle pulse per external rising edge
`timescale 1ns/100ps
module ccs_fail_mon import ccs_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic ext_rise,
    output logic fail,
    output logic fail_pulse
);
    logic [FAIL_W-1:0] cnt_reg, cnt_next;
    logic fail_reg, fail_next;
    logic pulse_reg, pulse_next;
    always_comb
    begin
        cnt_next = cnt_reg;
        fail_next = fail_reg;
        if (!enable)
        begin
            cnt_next = '0;
            fail_next = 1'b0;
        end
        else if (ext_rise)
        begin
            // clock is back: lift the fail level, flag stays sticky upstream
            cnt_next = '0;
            fail_next = 1'b0;
        end
        else if (cnt_reg == FAIL_W'(FAIL_CYC - 1))
            fail_next = 1'b1; // RL2
        else
            cnt_next = cnt_reg + 1'b1;
        pulse_next = fail_next & ~fail_reg;
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_reg <= '0;
            fail_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            fail_reg <= fail_next;
            pulse_reg <= pulse_next;
        end
    end
    assign fail = fail_reg;
    assign fail_pulse = pulse_reg;
    property p_fail_timeout;
        @(posedge clk) disable iff (srst)
        (enable && !ext_rise && !fail && cnt_reg == FAIL_W'(FAIL_CYC - 1)) |=> (fail && fail_pulse);
    endproperty
    a_fail_timeout: assert property (p_fail_timeout) else $error("monitor missed timeout"); // RL2
endmodule : ccs_fail_mon

// [hdl/ccs_clk_mux.sv]
// glitch-free selector over three sampled clock levels
// assumes every source toggles slower than clk
`timescale 1ns/100ps
module ccs_clk_mux import ccs_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] src,
    input wire ccs_src_t sel_req,
    output logic sys_clk,
    output ccs_src_t cur_sel,
    output logic switching
);
    typedef enum logic {MUX_RUN, MUX_PARK} ccs_mux_st_t;
    ccs_mux_st_t st_reg, st_next;
    ccs_src_t cur_reg, cur_next, tgt_reg, tgt_next;
    logic clk_reg, clk_next;
    function automatic logic lvl(input logic [2:0] s, input ccs_src_t k);
        lvl = s[k == SRC_HF ? 1 : (k == SRC_LF ? 2 : 0)];
    endfunction : lvl
    always_comb
    begin
        st_next = st_reg;
        cur_next = cur_reg;
        tgt_next = tgt_reg;
        unique case (st_reg)
            MUX_RUN:
            begin
                // only leave the old source on its low phase
                if (sel_req != cur_reg && !lvl(src, cur_reg)) // RL12
                begin
                    st_next = MUX_PARK;
                    tgt_next = sel_req;
                end
            end
            MUX_PARK:
            begin
                tgt_next = sel_req;
                // join the new source in its low phase, so its next edge is whole
                if (!lvl(src, sel_req)) // RL12
                begin
                    st_next = MUX_RUN;
                    cur_next = sel_req;
                end
            end
        endcase
        clk_next = (st_next == MUX_RUN) ? lvl(src, cur_next) : 1'b0;
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg <= MUX_RUN;
            cur_reg <= SRC_LF;
            tgt_reg <= SRC_LF;
            clk_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cur_reg <= cur_next;
            tgt_reg <= tgt_next;
            clk_reg <= clk_next;
        end
    end
    assign sys_clk = clk_reg;
    assign cur_sel = cur_reg;
    assign switching = (st_reg == MUX_PARK);
    property p_no_glitch;
        @(posedge clk) disable iff (srst)
        ($changed(cur_reg)) |-> (!sys_clk && !$past(sys_clk) && ($past(st_reg) == MUX_PARK));
    endproperty
    a_no_glitch: assert property (p_no_glitch) else $error("clock switched without parking"); // RL12
endmodule : ccs_clk_mux

// [tb/ccs_osc_model.sv]
// stand-ins for the external oscillator and the two internal oscillators
// assumes clk is the 25 MHz bus clock; every level changes just after its rising edge
`timescale 1ns/100ps
module ccs_osc_model (
    input wire logic clk,
    input wire logic ext_run,
    input wire logic [2:0] ext_half,
    output logic osc_pin_in,
    output logic hf_osc_in,
    output logic lf_osc_in
);
    int ext_cnt = 0;
    int ic = 0;
    initial
    begin
        osc_pin_in = 1'b0;
        hf_osc_in = 1'b0;
        lf_osc_in = 1'b0;
    end
    // internal sources free-run: high one toggles every 2 cycles, low one every 8
    always @(posedge clk)
    begin
        ic <= ic + 1;
        if (ic % 2 == 1)
            hf_osc_in <= ~hf_osc_in;
        if (ic % 8 == 7)
            lf_osc_in <= ~lf_osc_in;
    end
    // a failed crystal stops dead and parks low, the way a lost oscillator looks
    always @(posedge clk)
    begin
        if (!ext_run)
        begin
            ext_cnt <= 0;
            osc_pin_in <= 1'b0;
        end
        else if (ext_cnt + 1 >= int'(ext_half))
        begin
            ext_cnt <= 0;
            osc_pin_in <= ~osc_pin_in;
        end
        else
            ext_cnt <= ext_cnt + 1;
    end
endmodule : ccs_osc_model

// [tb/tb.sv]
// self-checking bench: straps, pins, clock rates and registers of the clock select block
// assumes ccs_osc_model drives the oscillator inputs; reads checked by a queue-fed monitor
`timescale 1ns/100ps
module tb;
    import ccs_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] m;} ccs_tb_exp_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] cfg_fosc = 3'h0;
    logic cfg_two_speed = 1'b0;
    logic cfg_failsafe = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic ext_run = 1'b1;
    logic [2:0] ext_half = 3'h2;
    logic osc_pin_in, hf_osc_in, lf_osc_in, avs_waitrequest, sys_clk;
    logic osc_out_o, osc_out_oe, osc_in_gpio_en, osc_out_gpio_en, irq;
    logic [31:0] avs_readdata;
    int err_count = 0;
    int n_tests = 0;
    int hi = 0;
    int s, o;
    ccs_tb_exp_t exp_q[$];

    ccs_osc_model ccs_osc_model_inst (.clk(clk), .ext_run(ext_run), .ext_half(ext_half),
        .osc_pin_in(osc_pin_in), .hf_osc_in(hf_osc_in), .lf_osc_in(lf_osc_in));
    ccs_top ccs_top_inst (.clk(clk), .srst(srst), .cfg_fosc(cfg_fosc), .cfg_two_speed(cfg_two_speed),
        .cfg_failsafe(cfg_failsafe), .osc_pin_in(osc_pin_in), .hf_osc_in(hf_osc_in),
        .lf_osc_in(lf_osc_in), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sys_clk(sys_clk), .osc_out_o(osc_out_o),
        .osc_out_oe(osc_out_oe), .osc_in_gpio_en(osc_in_gpio_en), .osc_out_gpio_en(osc_out_gpio_en),
        .irq(irq));

    initial
        forever #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic near(input int got, input int exp, input int tol);
        chk({31'h0, (got - exp <= tol) && (exp - got <= tol)}, 32'h1);
    endtask : near

    task automatic conclude();
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // read: d is the expected word, m the bits that matter; the request holds until waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        if (!wr)
            exp_q.push_back('{d, m});
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic do_reset(input logic [2:0] m, input logic ts, input logic fs);
        srst <= 1'b1;
        cfg_fosc <= m;
        cfg_two_speed <= ts;
        cfg_failsafe <= fs;
        ext_run <= 1'b1;
        ext_half <= 3'(2 + $urandom % 2);
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset

    task automatic cnt(input int n, output int sr, output int orr);
        logic ps, po;
        sr = 0;
        orr = 0;
        ps = sys_clk;
        po = osc_out_o;
        repeat (n)
        begin
            @(negedge clk);
            sr += int'(sys_clk && !ps);
            orr += int'(osc_out_o && !po);
            ps = sys_clk;
            po = osc_out_o;
        end
        @(posedge clk);
    endtask : cnt

    ////////////////////////////////////////////////////////////////////////////////
    // the monitor takes the oldest note whenever a read completes
    always @(posedge clk)
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
        begin
            chk(avs_readdata & exp_q[0].m, exp_q[0].v & exp_q[0].m);
            void'(exp_q.pop_front());
        end

    // a high pulse shorter than any source half period means a switch glitch
    always @(posedge clk)
        if (srst)
            hi <= 0;
        else if (sys_clk)
            hi <= hi + 1;
        else
        begin
            if (hi != 0)
                chk({31'h0, hi >= 2}, 32'h1);
            hi <= 0;
        end

    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(82));
        repeat (3) @(posedge clk);
        do_reset(MODE_EXT_CLK, 1'b0, 1'b0);
        bus(1'b0, OFS_CTRL, 32'h2, 32'hFFFFFFFF);
        bus(1'b0, OFS_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
        bus(1'b0, 4'h2, 32'h0, 32'hFFFFFFFF);
        // every mode: pin release, clock/4 output, clock source and reported mode
        for (int m = 0; m < 8; m++)
        begin
            do_reset(3'(m), 1'b0, 1'b0);
            repeat (30) @(posedge clk);
            chk({29'h0, osc_in_gpio_en, osc_out_gpio_en, osc_out_oe},
                {29'h0, m >= 6, m == 0 || m == 5 || m == 7, m == 4 || m == 6});
            bus(1'b0, OFS_STATUS, {25'h0, 3'(m), 3'h0, m < 6}, 32'hFFFFFF71);
            cnt(240, s, o);
            near(s, (m < 6) ? 240 / (2 * int'(ext_half)) : 60, 2);
            if (m == 4 || m == 6)
                near(o, s / 4, 1);
        end
        // two-speed start-up, software switching, then a lost crystal
        do_reset(MODE_HIGH_XTAL, 1'b1, 1'b1);
        bus(1'b0, OFS_STATUS, 32'h0, 32'h3);
        repeat (1100 * 2 * int'(ext_half)) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h3, 32'h3);
        bus(1'b0, OFS_IRQ_STAT, 32'h2, 32'h3);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, OFS_CTRL, {30'($urandom), 2'h3}, 32'h0);
        repeat (30) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0, 32'h1);
        cnt(160, s, o);
        near(s, 40, 2);
        bus(1'b1, OFS_CTRL, 32'h1, 32'h0);
        repeat (40) @(posedge clk);
        cnt(160, s, o);
        near(s, 10, 2);
        bus(1'b1, OFS_CTRL, 32'h0, 32'h0);
        avs_byteenable <= 4'h0;
        bus(1'b1, OFS_CTRL, 32'h3, 32'h0);
        avs_byteenable <= 4'hF;
        repeat (30) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h1, 32'h1);
        bus(1'b0, OFS_CTRL, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, OFS_IRQ_STAT, 32'h3, 32'h0);
        bus(1'b0, OFS_IRQ_STAT, 32'h0, 32'h3);
        ext_run <= 1'b0;
        repeat (80) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h4, 32'h5);
        bus(1'b0, OFS_IRQ_STAT, 32'h1, 32'h3);
        cnt(160, s, o);
        near(s, 10, 2);
        bus(1'b1, OFS_IRQ_MASK, 32'h1, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, OFS_IRQ_STAT, 32'h1, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        ext_run <= 1'b1;
        repeat (30) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0, 32'h4);
        repeat (5) @(posedge clk);
        conclude();
    end
endmodule : tb
